//--- dss_sig_if.sv
// interface carrying the combined timing selection between modules
// assumes a single system clock domain
`timescale 1ns/100ps
`default_nettype none
interface dss_sel_if;
  logic driver_timing_diff_input_sync;
  logic ext_encoder_z_input_sync;
  logic enc_sel;
  logic tim_out;
  modport mux (input driver_timing_diff_input_sync, input ext_encoder_z_input_sync, input enc_sel,
    output tim_out);
  modport core (output driver_timing_diff_input_sync, output ext_encoder_z_input_sync, output enc_sel,
    input tim_out);
endinterface : dss_sel_if
`default_nettype wire

//--- dss_pkg.sv
// constants for the driver signal status readout
// assumes one system clock, synchronous reset
`default_nettype none
package dss_pkg;
  localparam int DSS_N_IN = 6;
  localparam int DSS_N_OUT = 9;
  localparam int DSS_SYNC_STAGES = 2;
  // bit positions of the input group
  localparam int DSS_IN_ALARM = 0;
  localparam int DSS_IN_END = 1;
  localparam int DSS_IN_LC = 2;
  localparam int DSS_IN_MOVE = 3;
  localparam int DSS_IN_READY = 4;
  localparam int DSS_IN_TIMS = 5;
  localparam logic [5:0] DSS_IN_RST = 6'h00;
  localparam logic [8:0] DSS_OUT_RST = 9'h000;
  localparam logic DSS_SRC_DRIVER = 1'h0;
  localparam logic DSS_SRC_EXT = 1'h1;
endpackage : dss_pkg
`default_nettype wire

//--- dss_tim_mux.sv
// selector for the combined timing status bit
// assumes inputs already synchronised to clk_i
`timescale 1ns/100ps
`default_nettype none
module dss_tim_mux (
  input wire logic clk_i,
  input wire logic rst_i,
  dss_sel_if.mux sel
);
  // ************************************************************
  // selection
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sel.tim_out <= 1'h0;
    else if (sel.enc_sel == dss_pkg::DSS_SRC_EXT)
      sel.tim_out <= sel.ext_encoder_z_input_sync;
    else
      sel.tim_out <= sel.driver_timing_diff_input_sync;
  end

  AST_TIM_SRC: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 !$past(rst_i) |-> sel.tim_out == ($past(sel.enc_sel) ?
    $past(sel.ext_encoder_z_input_sync) : $past(sel.driver_timing_diff_input_sync)))
    else $error("timing status does not follow chosen source");
endmodule : dss_tim_mux
`default_nettype wire

//--- dss_status.sv
// driver signal status readout: one bit per driver signal
// assumes all pins synchronous to clk_i, active-high signal sense
//
// Operation
// - each status bit reads 0 when signal inactive, 1 when active
// - live monitor flag offered only in immediate mode, not sequences
// - output status shows internal state even when unassigned to a pin
// - external encoder Z input is among the readable status bits
// - combined timing bit follows timing input or Z per source select
`timescale 1ns/100ps
`default_nettype none
module dss_status (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] driver_in_i,
  input wire logic driver_timing_diff_input_i,
  input wire logic ext_encoder_z_input_i,
  input wire logic encoder_source_select_i,
  input wire logic [8:0] driver_out_state_i,
  input wire logic sequence_running_i,
  output logic [5:0] driver_signal_status_bit_o,
  output logic [8:0] driver_out_status_o,
  output logic timing_or_z_status_bit_o,
  output logic ext_z_status_o,
  output logic driver_ready_status_bit_o,
  output logic live_monitor_ok_o
);
  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic [7:0] raw;
  dss_sel_if sel ();

  assign raw = {ext_encoder_z_input_i, driver_timing_diff_input_i,
    driver_in_i};

  // two stages per pin; only the second stage feeds the status flops
  generate
    for (genvar g = 0; g < 8; g++)
    begin : g_sync
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          s1_q[g] <= 1'h0;
          s2_q[g] <= 1'h0;
        end
        else
        begin
          s1_q[g] <= raw[g];
          s2_q[g] <= s1_q[g];
        end
      end
    end
  endgenerate

  assign sel.driver_timing_diff_input_sync = s2_q[6];
  assign sel.ext_encoder_z_input_sync = s2_q[7];
  assign sel.enc_sel = encoder_source_select_i;

  dss_tim_mux dss_tim_mux_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel(sel.mux)
  );

  // ************************************************************
  // status registers
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      driver_signal_status_bit_o <= dss_pkg::DSS_IN_RST;
    else
      driver_signal_status_bit_o <= s2_q[5:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      driver_ready_status_bit_o <= 1'h0;
    else
      driver_ready_status_bit_o <= s2_q[dss_pkg::DSS_IN_READY];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ext_z_status_o <= 1'h0;
    else
      ext_z_status_o <= s2_q[7];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      driver_out_status_o <= dss_pkg::DSS_OUT_RST;
    else
      driver_out_status_o <= driver_out_state_i;
  end

  assign timing_or_z_status_bit_o = sel.tim_out;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      live_monitor_ok_o <= 1'h0;
    else
      live_monitor_ok_o <= !sequence_running_i;
  end

  // ************************************************************
  // check sequences
  // ************************************************************
  // pin to status: two synchroniser edges and one status edge
  sequence seq_pin_to_status;
    ##3 1'h1;
  endsequence

  // synchroniser alone: two edges
  sequence seq_sync_only;
    ##2 1'h1;
  endsequence

  // internal state and select pass one register
  sequence seq_one_edge;
    ##1 1'h1;
  endsequence

  // a stored sequence is running at this edge
  sequence seq_in_sequence;
    sequence_running_i;
  endsequence

  // immediate operation at this edge
  sequence seq_in_immediate;
    !sequence_running_i;
  endsequence

  // ************************************************************
  // checks
  // ************************************************************
  generate
    for (genvar b = 0; b < 6; b++)
    begin : g_in_chk
      AST_IN_BIT: assert property (
        @(posedge clk_i) disable iff (rst_i)
        seq_pin_to_status |->
        driver_signal_status_bit_o[b] == $past(driver_in_i[b], 3))
        else $error("input status bit is not its pin three edges back");
    end
  endgenerate

  AST_IN_LAT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    seq_pin_to_status |->
    driver_signal_status_bit_o == $past(driver_in_i, 3))
    else $error("input status not three cycles behind pin");

  AST_READY: assert property (
    @(posedge clk_i) disable iff (rst_i)
    driver_ready_status_bit_o == driver_signal_status_bit_o[4])
    else $error("ready status disagrees with status vector");

  AST_READY_PIN: assert property (
    @(posedge clk_i) disable iff (rst_i)
    seq_pin_to_status |-> driver_ready_status_bit_o ==
    $past(driver_in_i[dss_pkg::DSS_IN_READY], 3))
    else $error("ready status is not the ready pin three edges back");

  AST_OUT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    seq_one_edge |-> driver_out_status_o == $past(driver_out_state_i))
    else $error("output status not internal state");

  AST_OUT_HOLD: assert property (
    @(posedge clk_i) disable iff (rst_i)
    seq_one_edge ##0 $stable(driver_out_state_i) |=>
    $stable(driver_out_status_o))
    else $error("output status moved while internal state held");

  AST_EXT_ENCODER_Z_INPUT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    seq_pin_to_status |-> ext_z_status_o == $past(ext_encoder_z_input_i, 3))
    else $error("z status wrong");

  AST_TIM_LAT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    seq_pin_to_status |-> timing_or_z_status_bit_o ==
    ($past(encoder_source_select_i) ? $past(ext_encoder_z_input_i, 3) :
    $past(driver_timing_diff_input_i, 3)))
    else $error("combined timing bit does not follow chosen source");

  AST_LIVE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    seq_in_sequence |=> !live_monitor_ok_o)
    else $error("live monitor offered during sequence");

  AST_LIVE_ON: assert property (
    @(posedge clk_i) disable iff (rst_i)
    seq_in_immediate |=> live_monitor_ok_o)
    else $error("live monitor withheld in immediate operation");

  AST_SYNC: assert property (
    @(posedge clk_i) disable iff (rst_i)
    seq_sync_only ##0 $changed(driver_signal_status_bit_o) |->
    $past(s1_q[5:0], 2) == driver_signal_status_bit_o)
    else $error("status bypassed synchroniser");

  AST_SYNC_Z: assert property (
    @(posedge clk_i) disable iff (rst_i)
    seq_sync_only ##0 $changed(ext_z_status_o) |->
    $past(s1_q[7], 2) == ext_z_status_o)
    else $error("z status bypassed synchroniser");

  AST_RST_CLEAR: assert property (
    @(posedge clk_i) rst_i |=>
    driver_signal_status_bit_o == dss_pkg::DSS_IN_RST &&
    driver_out_status_o == dss_pkg::DSS_OUT_RST &&
    !timing_or_z_status_bit_o && !ext_z_status_o &&
    !driver_ready_status_bit_o && !live_monitor_ok_o)
    else $error("status not inactive after reset");
endmodule : dss_status
`default_nettype wire

//--- dss_drv_model.sv
// model of the motor driver and external encoder pins
// assumes the bench changes its stimulus at the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module dss_drv_model (
  input wire logic clk_i,
  input wire logic cur_on_i,
  input wire logic [7:0] pat_i,
  output logic [5:0] drv_o,
  output logic driver_timing_diff_input_o,
  output logic ext_encoder_z_input_o
);
  logic [2:0] dly_q;
  // ready rises only some cycles after current is switched on
  always_ff @(posedge clk_i)
  begin
    if (!cur_on_i)
      dly_q <= 3'h0;
    else if (dly_q != 3'h7)
      dly_q <= dly_q + 3'h1;
  end
  // pattern bit 4 stands for a driver that is ready already
  assign drv_o = {pat_i[5], pat_i[4] | (dly_q == 3'h7),
    pat_i[3:0]};
  assign driver_timing_diff_input_o = pat_i[6];
  assign ext_encoder_z_input_o = pat_i[7];
endmodule : dss_drv_model
`default_nettype wire

//--- tb_driver_signal_status_readout.sv
// self-checking bench for the driver signal status readout
// assumes dss_status and dss_drv_model are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_driver_signal_status_readout;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cur_on = 1'b0;
  logic sel = 1'b0;
  logic seq = 1'b0;
  logic [7:0] pat = 8'h00;
  logic [8:0] outs = 9'h000;
  logic [5:0] drv, st;
  logic [8:0] ost;
  logic driver_timing_diff_input, ext_encoder_z_input, tz, ez, rdy, live;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  initial forever #20 clk_i = ~clk_i;
  dss_drv_model dss_drv_model_i (.clk_i(clk_i), .cur_on_i(cur_on),
    .pat_i(pat), .drv_o(drv), .driver_timing_diff_input_o(driver_timing_diff_input), .ext_encoder_z_input_o(ext_encoder_z_input));
  dss_status dss_status_i (.clk_i(clk_i), .rst_i(rst_i),
    .driver_in_i(drv), .driver_timing_diff_input_i(driver_timing_diff_input),
    .ext_encoder_z_input_i(ext_encoder_z_input), .encoder_source_select_i(sel),
    .driver_out_state_i(outs), .sequence_running_i(seq),
    .driver_signal_status_bit_o(st), .driver_out_status_o(ost),
    .timing_or_z_status_bit_o(tz), .ext_z_status_o(ez),
    .driver_ready_status_bit_o(rdy), .live_monitor_ok_o(live));
  task automatic chk_in(input string what, input logic [5:0] got,
    input logic [5:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_in
  task automatic chk_out(input string what, input logic [8:0] got,
    input logic [8:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_out
  task automatic chk_bit(input string what, input logic got,
    input logic exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic t_in;
    for (int i = 0; i < 8; i++)
    begin
      pat = 8'h01 << i;
      repeat (4) @(negedge clk_i);
      chk_in("input status", st, pat[5:0]);
      chk_bit("ready status", rdy, pat[4]);
      chk_bit("z status", ez, pat[7]);
    end
  endtask : t_in
  task automatic t_tim;
    for (int i = 0; i < 4; i++)
    begin
      sel = i[1];
      pat = i[0] ? 8'h40 : 8'h80;
      repeat (4) @(negedge clk_i);
      chk_bit("timing status", tz, sel ? pat[7] : pat[6]);
    end
  endtask : t_tim
  task automatic t_out;
    outs = 9'h155;
    seq = 1'b1;
    repeat (2) @(negedge clk_i);
    chk_out("output status", ost, 9'h155);
    chk_bit("live monitor", live, 1'b0);
    outs = 9'h0AA;
    seq = 1'b0;
    repeat (2) @(negedge clk_i);
    chk_out("output status", ost, 9'h0AA);
    chk_bit("live monitor", live, 1'b1);
  endtask : t_out
  task automatic t_ready;
    int n;
    n = 0;
    pat = 8'h00;
    cur_on = 1'b1;
    repeat (2) @(negedge clk_i);
    chk_bit("ready early", rdy, 1'b0);
    while (rdy !== 1'b1 && n < 30)
    begin
      @(negedge clk_i);
      n++;
    end
    chk_bit("ready", rdy, 1'b1);
    chk_in("input status", st, 6'h10);
  endtask : t_ready
  task automatic t_reset;
    pat = 8'hFF;
    outs = 9'h1FF;
    repeat (4) @(negedge clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk_in("input status in reset", st, 6'h00);
    chk_out("output status in reset", ost, 9'h000);
    chk_bit("ready in reset", rdy, 1'b0);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk_in("input status after reset", st, 6'h3F);
    chk_out("output status after reset", ost, 9'h1FF);
    chk_bit("z after reset", ez, 1'b1);
    chk_bit("timing after reset", tz, 1'b1);
  endtask : t_reset
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      complete_run();
    end
  end
  initial
  begin
    repeat (16) @(negedge clk_i);
    chk_in("input status at reset", st, 6'h00);
    chk_out("output status at reset", ost, 9'h000);
    chk_bit("timing at reset", tz, 1'b0);
    chk_bit("z at reset", ez, 1'b0);
    chk_bit("ready at reset", rdy, 1'b0);
    chk_bit("live at reset", live, 1'b0);
    rst_i = 1'b0;
    t_in();
    t_tim();
    t_out();
    t_ready();
    t_reset();
    complete_run();
  end
endmodule : tb_driver_signal_status_readout
`default_nettype wire
